//--- src/hwk_host_wake.sv
/*
  Host interface front end with trickle wake logic: LPC I/O target with
  window decode, DMA request encoder, clock-run, management interrupt
  and wake request drivers. Assumes LAD and frame are synchronous to
  the LPC clock, the I/O user logic runs on the LPC clock and answers
  a read strobe with data in the same cycle, and all open-drain pins
  are resolved outside from the enables.
*/
`timescale 1ns/1ps
module hwk_host_wake
    import hwk_pkg::*;
(
    // Trickle domain
    input logic i_sys_clk,
    input logic i_nrst,
    input logic i_main_power_ok,
    input logic i_ring_indicate_1_n,
    input logic i_ring_indicate_2_n,
    input logic i_ring_indicate_3_n,
    input logic i_ring_indicate_4_n,
    input logic i_watchdog_event,
    input logic [GP_N-1:0] i_gen_pin_in,
    input logic [GP_N-1:0] i_gen_pin_wake_low,
    input logic [GP_N-1:0] i_gen_pin_drive,
    output logic [GP_N-1:0] o_gen_pin_oe,
    input logic [EV_N-1:0] i_wake_enable,
    input logic [EV_N-1:0] i_wake_clear,
    input logic [EV_N-1:0] i_mgmt_enable,
    output logic [EV_N-1:0] o_wake_status,
    output logic o_wake_request_out_n_o,
    output logic o_wake_request_out_n_oe,
    output logic o_mgmt_irq_n_o,
    output logic o_mgmt_irq_n_oe,
    input logic i_clk_needed,
    input logic i_clkrun_n,
    output logic o_clkrun_n_o,
    output logic o_clkrun_n_oe,
    input logic i_dma_req,
    input logic [2:0] i_dma_chan,
    input logic i_dma_active,
    // LPC domain
    input logic i_lpc_clk,
    input logic i_lpc_rst_n,
    input logic i_host_bus_select,
    input logic i_lpcpd_n,
    input logic i_lframe_n,
    input logic [3:0] i_lad,
    output logic [3:0] o_lad_o,
    output logic o_lad_oe,
    output logic o_ldrq_n,
    input logic [RI_N-1:0][15:0] i_uart_base,
    input logic [15:0] i_rt_base,
    input logic [15:0] i_cfg_base,
    input logic [15:0] i_par_base,
    input hwk_par_mode_t i_par_mode,
    output hwk_unit_t o_io_unit,
    output logic [3:0] o_io_offset,
    output logic [7:0] o_io_wdata,
    output logic o_io_wr,
    output logic o_io_rd,
    input logic [7:0] i_io_rdata
);
    // Trickle-domain state
    typedef struct packed {
        logic dma_tgl;           // Request event, toggled per request
        logic [2:0] dma_chan;    // Held until the next request
        logic dma_act;
        logic ck_s1;             // Clock-run line synchroniser
        logic ck_s2;
        logic pg_s1;             // Main power good synchroniser
        logic pg_s2;
        logic clkrun_oe;
        logic wake_oe;
        logic mgmt_oe;
        logic od_low;            // Open-drain data, always low
        logic [GP_N-1:0] gp_oe;
    } hwk_sys_state_t;

    // LPC-domain state
    typedef struct packed {
        hwk_lpc_st_t st;
        logic [1:0] cnt;         // Nibble counter within a field
        logic wr;                // Current cycle is a write
        logic [15:0] addr;
        logic [7:0] data;
        hwk_unit_t unit;
        logic [3:0] ofs;
        logic [3:0] lad_o;
        logic lad_oe;
        logic io_rd;
        logic io_wr;
        logic pd_s1;             // Powerdown synchroniser
        logic pd_s2;
        logic pg_s1;             // Main power good synchroniser
        logic pg_s2;
        logic sel_s1;            // Host bus select synchroniser
        logic sel_s2;
        logic t1;                // DMA toggle synchroniser and edge
        logic t2;
        logic t3;
        logic [5:0] sh;          // LDRQ frame shifter
        logic ldrq;
    } hwk_lpc_state_t;

    localparam hwk_sys_state_t SYS_RST = '{default: '0};
    localparam hwk_lpc_state_t LPC_RST = '{st: L_IDLE, unit: U_NONE, sh: LDRQ_IDLE, ldrq: 1'b1, default: '0};

    hwk_sys_state_t s_q;
    hwk_sys_state_t s_d;
    hwk_lpc_state_t l_q;
    hwk_lpc_state_t l_d;
    logic act;                  // LPC decode allowed
    logic pd;                   // LPC powerdown in force
    logic dma_edge;             // New DMA request seen
    logic [15:0] nxt_addr;      // Address with the incoming nibble
    hwk_hit_t hit;              // Decode of nxt_addr

    hwk_wake_if #(.N(EV_N)) w ();

    // Membership and offset of a in the window at base b, wrapping below b
    function automatic logic in_win(input logic [15:0] a, input logic [15:0] b, input logic [15:0] s);
        logic [15:0] dif;
        dif = a - b;
        in_win = dif < s;
    endfunction : in_win

    function automatic logic [3:0] ofs_of(input logic [15:0] a, input logic [15:0] b);
        logic [15:0] dif;
        dif = a - b;
        ofs_of = dif[3:0];
    endfunction : ofs_of

    // Window decode; last match wins, so overlapping bases favour uarts
    function automatic hwk_hit_t decode(input logic [15:0] a);
        hwk_hit_t h;
        logic ext;
        logic [15:0] pspan;
        h = '{unit: U_NONE, ofs: 4'h0};
        ext = (i_par_mode == PAR_ECP) || (i_par_mode == PAR_ECP_EPP);
        pspan = (i_par_mode == PAR_SPP || i_par_mode == PAR_ECP) ? SPP_SPAN : EPP_SPAN;
        if (ext && in_win(a, i_par_base + ECP_OFS, ECP_SPAN)) begin
            h = '{unit: U_PAR_EXT, ofs: ofs_of(a, i_par_base + ECP_OFS)};
        end
        if (in_win(a, i_par_base, pspan)) begin
            h = '{unit: U_PAR, ofs: ofs_of(a, i_par_base)};
        end
        if (in_win(a, i_cfg_base, CFG_SPAN)) begin
            h = '{unit: U_CONFIG, ofs: ofs_of(a, i_cfg_base)};
        end
        if (in_win(a, i_rt_base, RT_SPAN)) begin
            h = '{unit: U_RUNTIME, ofs: ofs_of(a, i_rt_base)};
        end
        for (int i = RI_N - 1; i >= 0; i--) begin
            if (in_win(a, i_uart_base[i], UART_SPAN)) begin
                h = '{unit: hwk_unit_t'(4'(i) + 4'h1), ofs: ofs_of(a, i_uart_base[i])};
            end
        end
        return h;
    endfunction : decode

    // Wake sources wired into the carrier, rings active low
    assign w.raw = {i_gen_pin_in, i_watchdog_event, i_ring_indicate_4_n, i_ring_indicate_3_n,
                    i_ring_indicate_2_n, i_ring_indicate_1_n};
    assign w.invert = {i_gen_pin_wake_low, 1'b0, {RI_N{1'b1}}};
    assign w.enable = i_wake_enable;
    assign w.clear = i_wake_clear;

    hwk_wake u_wake (
        .i_sys_clk (i_sys_clk),
        .i_nrst (i_nrst),
        .w (w.core)
    );

    // Trickle-domain next state
    always_comb begin
        s_d = s_q;
        s_d.od_low = 1'b0;
        s_d.ck_s1 = i_clkrun_n;
        s_d.ck_s2 = s_q.ck_s1;
        s_d.pg_s1 = i_main_power_ok;
        s_d.pg_s2 = s_q.pg_s1;
        // Pins never drive while main power is absent
        s_d.gp_oe = i_gen_pin_drive & {GP_N{s_q.pg_s2}};
        // Mode select plays no part: both outputs exist in either mode
        s_d.wake_oe = w.pending;
        s_d.mgmt_oe = |(w.status & i_mgmt_enable);
        // Pull clock-run only while it reads high; releases once seen low
        s_d.clkrun_oe = (w.pending || i_clk_needed) && s_q.ck_s2;
        // Capture a request and flip the event toggle
        if (i_dma_req) begin
            s_d.dma_tgl = !s_q.dma_tgl;
            s_d.dma_chan = i_dma_chan;
            s_d.dma_act = i_dma_active;
        end
    end

    // Trickle-domain registers, reset by trickle power-on only
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= SYS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign nxt_addr = {l_q.addr[11:0], i_lad};
    assign hit = decode(nxt_addr);
    assign act = l_q.pd_s2 && l_q.pg_s2 && !l_q.sel_s2;
    assign pd = !l_q.pd_s2;
    assign dma_edge = l_q.t2 ^ l_q.t3;

    // LPC-domain next state
    always_comb begin
        l_d = l_q;
        l_d.io_rd = 1'b0;
        l_d.io_wr = 1'b0;
        l_d.pd_s1 = i_lpcpd_n;
        l_d.pd_s2 = l_q.pd_s1;
        l_d.pg_s1 = i_main_power_ok;
        l_d.pg_s2 = l_q.pg_s1;
        l_d.sel_s1 = i_host_bus_select;
        l_d.sel_s2 = l_q.sel_s1;
        l_d.t1 = s_q.dma_tgl;
        l_d.t2 = l_q.t1;
        l_d.t3 = l_q.t2;
        if (!act) begin
            // Powerdown, ISA mode or no main power: bus left alone
            l_d.st = L_IDLE;
            l_d.lad_oe = 1'b0;
        end else if (!i_lframe_n) begin
            // Frame low aborts anything and may start a new cycle
            l_d.lad_oe = 1'b0;
            l_d.st = (i_lad == LAD_START) ? L_CT : L_IDLE;
        end else begin
            unique case (l_q.st)
                L_IDLE: begin
                    l_d.lad_oe = 1'b0;
                end
                L_CT: begin
                    // Only I/O cycles are claimed; others are ignored
                    l_d.wr = i_lad[1];
                    l_d.cnt = 2'h0;
                    l_d.st = (i_lad[3:2] == CT_IO && !i_lad[0]) ? L_ADDR : L_IDLE;
                end
                L_ADDR: begin
                    l_d.addr = nxt_addr;
                    l_d.cnt = l_q.cnt + 2'h1;
                    if (l_q.cnt == NIB_LAST) begin
                        l_d.unit = hit.unit;
                        l_d.ofs = hit.ofs;
                        l_d.cnt = 2'h0;
                        if (hit.unit == U_NONE) begin
                            l_d.st = L_IDLE;
                        end else begin
                            l_d.st = l_q.wr ? L_WDATA : L_HTAR;
                        end
                    end
                end
                L_WDATA: begin
                    // Low nibble first
                    l_d.data = {i_lad, l_q.data[7:4]};
                    l_d.cnt = l_q.cnt + 2'h1;
                    if (l_q.cnt[0]) begin
                        l_d.cnt = 2'h0;
                        l_d.st = L_HTAR;
                    end
                end
                L_HTAR: begin
                    l_d.cnt = l_q.cnt + 2'h1;
                    if (l_q.cnt == 2'h0) begin
                        l_d.io_rd = !l_q.wr;
                    end else begin
                        // Take the turnaround and answer ready at once
                        if (!l_q.wr) begin
                            l_d.data = i_io_rdata;
                        end
                        l_d.io_wr = l_q.wr;
                        l_d.lad_o = LAD_SYNC_OK;
                        l_d.lad_oe = 1'b1;
                        l_d.cnt = 2'h0;
                        l_d.st = L_SYNC;
                    end
                end
                L_SYNC: begin
                    l_d.lad_o = l_q.wr ? LAD_TAR : l_q.data[3:0];
                    l_d.st = l_q.wr ? L_DTAR : L_RDATA;
                end
                L_RDATA: begin
                    l_d.lad_o = l_q.data[7:4];
                    l_d.cnt = l_q.cnt + 2'h1;
                    if (l_q.cnt[0]) begin
                        l_d.lad_o = LAD_TAR;
                        l_d.cnt = 2'h0;
                        l_d.st = L_DTAR;
                    end
                end
                L_DTAR: begin
                    // One cycle of ones driven, then release
                    l_d.lad_oe = 1'b0;
                    l_d.st = L_IDLE;
                end
            endcase
        end
        // Request line: start, channel msb first, active, then idle high
        l_d.sh = {l_q.sh[4:0], 1'b1};
        l_d.ldrq = l_q.sh[5];
        if (pd) begin
            l_d.sh = LDRQ_IDLE;
            l_d.ldrq = 1'b0;
        end else if (dma_edge) begin
            // Channel bits settled with the toggle, two link edges before this use
            l_d.sh = {1'b0, s_q.dma_chan, s_q.dma_act, 1'b1};
        end
    end

    // LPC-domain registers, cleared by the host reset
    always_ff @(posedge i_lpc_clk or negedge i_lpc_rst_n) begin
        if (!i_lpc_rst_n) begin
            l_q <= LPC_RST;
        end else begin
            l_q <= l_d;
        end
    end

    // Outputs, each straight from a flop
    assign o_gen_pin_oe = s_q.gp_oe;
    assign o_wake_status = w.status;
    assign o_wake_request_out_n_o = s_q.od_low;
    assign o_wake_request_out_n_oe = s_q.wake_oe;
    assign o_mgmt_irq_n_o = s_q.od_low;
    assign o_mgmt_irq_n_oe = s_q.mgmt_oe;
    assign o_clkrun_n_o = s_q.od_low;
    assign o_clkrun_n_oe = s_q.clkrun_oe;
    assign o_lad_o = l_q.lad_o;
    assign o_lad_oe = l_q.lad_oe;
    assign o_ldrq_n = l_q.ldrq;
    assign o_io_unit = l_q.unit;
    assign o_io_offset = l_q.ofs;
    assign o_io_wdata = l_q.data;
    assign o_io_wr = l_q.io_wr;
    assign o_io_rd = l_q.io_rd;

    // Read strobe is followed by a ready sync on the bus
    sequence s_rd_start;
        o_io_rd && i_lframe_n && act;
    endsequence
    sequence s_sync_out;
        o_lad_oe && o_lad_o == LAD_SYNC_OK;
    endsequence
    sequence s_ldrq_frame;
        !o_ldrq_n ##5 o_ldrq_n;
    endsequence

    chk_lad_release:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n)
        !i_lframe_n |=> !o_lad_oe)
        else $error("LAD driven after frame went low");

    chk_no_decode:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n)
        !act |=> !o_lad_oe && !o_io_rd && !o_io_wr)
        else $error("LPC decode while inactive");

    chk_rd_sync:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n)
        s_rd_start |=> s_sync_out)
        else $error("No sync after read strobe");

    chk_wr_sync:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n)
        o_io_wr |-> s_sync_out)
        else $error("Write strobe without sync");

    chk_ldrq_pd:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n)
        pd |=> !o_ldrq_n)
        else $error("Request line not low in powerdown");

    chk_ldrq_frame:
    assert property (@(posedge i_lpc_clk) disable iff (!i_lpc_rst_n || pd)
        dma_edge |=> ##1 s_ldrq_frame)
        else $error("Bad request frame on request line");

    chk_gp_oe_power:
    assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        !s_q.pg_s2 |=> o_gen_pin_oe == '0)
        else $error("Wake pin driven without main power");

    chk_wake_follow:
    assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ##1 o_wake_request_out_n_oe == $past(w.pending))
        else $error("Wake request does not follow pending");

    chk_clkrun_cause:
    assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_clkrun_n_oe |-> $past(s_q.ck_s2) && ($past(w.pending) || $past(i_clk_needed)))
        else $error("Clock-run pulled without cause");
endmodule : hwk_host_wake

//--- src/hwk_pkg.sv
/*
  Shared constants and types for the host interface and wake block.
  Assumes an LPC host on its own clock, a trickle-powered system clock,
  and window bases supplied by configuration logic outside this block.
*/
// Operation
// - Trickle power alone keeps wake output working
// - Wake sources: four rings, watchdog, wake pins
// - Unpowered main supply: wake pins input only
// - Only the nineteen listed pins feed wake
// - Pins wake in plain or alternate use
// - Wake status and enables survive main loss
// - Wake logic runs from trickle clock domain
// - Select high means ISA, else LPC
// - Host registers are eight bits wide
// - Relocatable windows: uart 8, runtime 16, config 2
// - Parallel 4 or 8, extended adds 400h-402h
// - Frame marks cycle start and abort
// - LPC reset input resets LPC logic
// - LDRQ carries encoded DMA requests
// - LAD is bidirectional multiplexed nibble bus
// - Powerdown input parks LPC logic safely
// - Clock-run pulled low to restart clock
// - Management interrupt open drain event notice
// - Wake request output is open drain
// - Wake, interrupt, clock stay in both modes
// - No LPC decode without main power good
// - Trickle power-on reset initialises wake logic
package hwk_pkg;
    // Event vector layout: rings, watchdog, wake pins
    localparam int RI_N = 4;
    localparam int GP_N = 19;
    localparam int EV_N = RI_N + 1 + GP_N;
    // LPC field codes
    localparam logic [3:0] LAD_START = 4'h0;
    localparam logic [3:0] LAD_SYNC_OK = 4'h0;
    localparam logic [3:0] LAD_TAR = 4'hf;
    localparam logic [1:0] CT_IO = 2'h0;
    localparam logic [1:0] NIB_LAST = 2'h3;
    // Window spans and extended offset
    localparam logic [15:0] UART_SPAN = 16'h0008;
    localparam logic [15:0] RT_SPAN = 16'h0010;
    localparam logic [15:0] CFG_SPAN = 16'h0002;
    localparam logic [15:0] SPP_SPAN = 16'h0004;
    localparam logic [15:0] EPP_SPAN = 16'h0008;
    localparam logic [15:0] ECP_OFS = 16'h0400;
    localparam logic [15:0] ECP_SPAN = 16'h0003;
    // DMA request line idle pattern
    localparam logic [5:0] LDRQ_IDLE = 6'h3f;
    typedef enum logic [3:0] {
        U_NONE, U_UART1, U_UART2, U_UART3, U_UART4,
        U_RUNTIME, U_CONFIG, U_PAR, U_PAR_EXT
    } hwk_unit_t;
    typedef enum logic [1:0] {PAR_SPP, PAR_EPP, PAR_ECP, PAR_ECP_EPP} hwk_par_mode_t;
    typedef enum logic [2:0] {
        L_IDLE, L_CT, L_ADDR, L_WDATA, L_HTAR, L_SYNC, L_RDATA, L_DTAR
    } hwk_lpc_st_t;
    typedef struct packed {
        hwk_unit_t unit;
        logic [3:0] ofs;
    } hwk_hit_t;
endpackage : hwk_pkg

//--- src/hwk_wake_if.sv
/*
  Carrier between the top and the trickle wake unit.
  Assumes both ends run on the trickle-domain system clock.
*/
`timescale 1ns/1ps
interface hwk_wake_if #(parameter int N = 24);
    logic [N-1:0] raw;     // Unsynchronised event levels
    logic [N-1:0] invert;  // Set where the source is active low
    logic [N-1:0] enable;  // Events allowed onto the wake request
    logic [N-1:0] clear;   // Status clear, one-cycle pulses
    logic [N-1:0] status;  // Sticky event flags
    logic pending;         // Any enabled flag set
    modport core (input raw, invert, enable, clear, output status, pending);
    modport ctrl (output raw, invert, enable, clear, input status, pending);
endinterface : hwk_wake_if

//--- src/hwk_wake.sv
/*
  Trickle-domain wake event unit: synchronises event levels, catches
  active edges into sticky flags and flags an enabled pending event.
  Assumes its clock and reset come from the trickle supply alone.
*/
`timescale 1ns/1ps
module hwk_wake
    import hwk_pkg::*;
(
    input logic i_sys_clk,
    input logic i_nrst,
    hwk_wake_if.core w
);
    typedef struct packed {
        logic [EV_N-1:0] s1;   // First synchroniser stage
        logic [EV_N-1:0] s2;   // Second synchroniser stage
        logic [EV_N-1:0] lvl;  // Previous active level
        logic [EV_N-1:0] st;   // Sticky flags
    } hwk_wake_state_t;

    // Previous level starts active, so a source idling high behind an inversion shows no false edge after reset
    localparam hwk_wake_state_t WAKE_RST = '{lvl: '1, default: '0};

    hwk_wake_state_t q;
    hwk_wake_state_t d;
    logic [EV_N-1:0] rise;

    // Active-level edge, taken only after two stages
    assign rise = (q.s2 ^ w.invert) & ~q.lvl;

    // Next state; a new edge beats a clear in the same cycle
    always_comb begin
        d = q;
        d.s1 = w.raw;
        d.s2 = q.s1;
        d.lvl = q.s2 ^ w.invert;
        d.st = (q.st & ~w.clear) | rise;
    end

    // Only the trickle reset touches these; main power loss does not
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q <= WAKE_RST;
        end else begin
            q <= d;
        end
    end

    assign w.status = q.st;
    assign w.pending = |(q.st & w.enable);

    chk_event_sets:
    assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        rise != '0 |=> (q.st & $past(rise)) == $past(rise))
        else $error("Wake edge did not set its flag");

    chk_status_hold:
    assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        1'b1 |=> ($past(q.st) & ~$past(w.clear) & ~q.st) == '0)
        else $error("Wake flag lost without a clear");
endmodule : hwk_wake

//--- testbench/hwk_lpc_host.sv
/*
  Host-side LPC model: drives frame and LAD one nibble per cycle.
  Assumes LAD is pulled up and the device drive is resolved outside.
*/
`timescale 1ns/1ps
module hwk_lpc_host (
    input wire logic i_clk,
    output logic o_lframe_n,
    output logic [3:0] o_lad,
    input wire logic [3:0] i_lad_o,
    input wire logic i_lad_oe
);
    // Idle bus: frame high, LAD released to the pull-up level
    initial begin
        o_lframe_n = 1'b1;
        o_lad = 4'hf;
    end
    // One nibble, changed on the falling edge
    task put(input logic f, input logic [3:0] v);
        @(negedge i_clk);
        o_lframe_n = f;
        o_lad = v;
    endtask : put
    // One I/O cycle; ok only when the target answers a ready sync
    task io(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q, output logic ok);
        ok = 1'b0;
        q = 8'h00;
        put(1'b0, 4'h0);
        put(1'b1, wr ? 4'h2 : 4'h0);
        // Address high nibble first
        for (int i = 3; i >= 0; i--) put(1'b1, a[i*4 +: 4]);
        // Data low nibble first
        if (wr) begin
            put(1'b1, d[3:0]);
            put(1'b1, d[7:4]);
        end
        put(1'b1, 4'hf);
        put(1'b1, 4'hf);
        // Bounded wait, a silent target must not hang the host
        for (int i = 0; i < 6 && !ok; i++) begin
            @(negedge i_clk);
            ok = (i_lad_oe === 1'b1) && (i_lad_o === 4'h0);
        end
        if (ok && !wr) begin
            @(negedge i_clk);
            q[3:0] = i_lad_o;
            @(negedge i_clk);
            q[7:4] = i_lad_o;
        end
        repeat (3) @(negedge i_clk);
    endtask : io
endmodule : hwk_lpc_host

//--- testbench/tb_hwk_host_wake.sv
/*
  Self-checking bench for the host interface and wake block.
  Assumes the LPC host model beside it and pulled-up open-drain lines.
*/
`timescale 1ns/1ps
module tb_hwk_host_wake;
    import hwk_pkg::*;
    logic i_sys_clk = 0, i_lpc_clk = 0, nrst = 0, prst = 0;
    logic pwr = 1, sel = 0, pd_n = 1, need = 0, dreq = 0, dact = 0, ok;
    logic [2:0] dchan = 0;
    logic [23:0] src = 0, wen = 0, wclr = 0, men = 0, stat;
    logic [18:0] wl = 0, drv = 0, gp_oe;
    logic fr_n, wk_o, wk_oe, mi_o, mi_oe, cr_o, cr_oe, lad_oe, ldrq_n, wr, rd;
    logic [3:0] hlad, lad_o, ofs, wo;
    logic [7:0] wdata, wd, q, d;
    hwk_unit_t unit, wu;
    hwk_par_mode_t pm = PAR_SPP;
    logic [3:0][15:0] ub = {16'h02e8, 16'h03e8, 16'h02f8, 16'h03f8};
    int num_errors = 0, tests_run = 0, seed = 12, cyc = 0;
    // Trickle clock 40 ns, link clock 30 ns with an odd phase
    initial forever #20 i_sys_clk = ~i_sys_clk;
    initial begin
        #7;
        forever #15 i_lpc_clk = ~i_lpc_clk;
    end
    hwk_host_wake i_dut (.i_sys_clk(i_sys_clk), .i_nrst(nrst), .i_main_power_ok(pwr),
        .i_ring_indicate_1_n(~src[0]), .i_ring_indicate_2_n(~src[1]), .i_ring_indicate_3_n(~src[2]),
        .i_ring_indicate_4_n(~src[3]), .i_watchdog_event(src[4]), .i_gen_pin_in(src[23:5] ^ wl),
        .i_gen_pin_wake_low(wl), .i_gen_pin_drive(drv), .o_gen_pin_oe(gp_oe), .i_wake_enable(wen),
        .i_wake_clear(wclr), .i_mgmt_enable(men), .o_wake_status(stat), .o_wake_request_out_n_o(wk_o),
        .o_wake_request_out_n_oe(wk_oe), .o_mgmt_irq_n_o(mi_o), .o_mgmt_irq_n_oe(mi_oe),
        .i_clk_needed(need), .i_clkrun_n(~cr_oe), .o_clkrun_n_o(cr_o), .o_clkrun_n_oe(cr_oe),
        .i_dma_req(dreq), .i_dma_chan(dchan), .i_dma_active(dact), .i_lpc_clk(i_lpc_clk),
        .i_lpc_rst_n(prst), .i_host_bus_select(sel), .i_lpcpd_n(pd_n), .i_lframe_n(fr_n),
        .i_lad(lad_oe ? lad_o : hlad), .o_lad_o(lad_o), .o_lad_oe(lad_oe), .o_ldrq_n(ldrq_n),
        .i_uart_base(ub), .i_rt_base(16'h0600), .i_cfg_base(16'h002e), .i_par_base(16'h0378),
        .i_par_mode(pm), .o_io_unit(unit), .o_io_offset(ofs), .o_io_wdata(wdata), .o_io_wr(wr),
        .o_io_rd(rd), .i_io_rdata({unit, ofs}));
    hwk_lpc_host host (.i_clk(i_lpc_clk), .o_lframe_n(fr_n), .o_lad(hlad), .i_lad_o(lad_o), .i_lad_oe(lad_oe));
    // Capture what each write strobe delivers
    always @(negedge i_lpc_clk) begin
        if (wr === 1'b1) begin
            wu <= unit;
            wo <= ofs;
            wd <= wdata;
        end
    end
    // Hang guard
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task acc(input logic w, input logic [15:0] a, input logic [7:0] dd, input logic eok, input logic [7:0] eq);
        host.io(w, a, dd, q, ok);
        chk("sync", eok, ok);
        if (eok && !w) chk("rdata", eq, q);
    endtask : acc
    task pulse_clear();
        @(negedge i_sys_clk);
        wclr = '1;
        @(negedge i_sys_clk);
        wclr = 0;
    endtask : pulse_clear
    task report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        repeat (16) @(negedge i_sys_clk);
        nrst = 1;
        prst = 1;
        repeat (10) @(negedge i_lpc_clk);
        pulse_clear();
        d = $random(seed);
        acc(1, 16'h03fb, d, 1, 0);
        chk("wunit", U_UART1, wu);
        chk("wofs", 3, wo);
        chk("wdata", d, wd);
        for (int k = 0; k < 4; k++) acc(0, ub[k] + 16'h7, 0, 1, {4'(k + 1), 4'h7});
        acc(0, 16'h060f, 0, 1, {U_RUNTIME, 4'hf});
        acc(0, 16'h002f, 0, 1, {U_CONFIG, 4'h1});
        acc(0, 16'h0030, 0, 0, 0);
        // Every parallel mode, window edges
        for (int m = 0; m < 4; m++) begin
            pm = hwk_par_mode_t'(m);
            acc(0, 16'h037f, 0, m[0], {U_PAR, 4'h7});
            acc(0, 16'h077a, 0, m[1], {U_PAR_EXT, 4'h2});
            acc(0, 16'h077b, 0, 0, 0);
        end
        // Broken cycle, then a fresh one
        host.put(0, 4'h0);
        host.put(1, 4'h0);
        host.put(1, 4'h0);
        acc(0, 16'h060e, 0, 1, {U_RUNTIME, 4'he});
        // No main power, then ISA select
        for (int c = 0; c < 2; c++) begin
            pwr = c[0];
            sel = c[0];
            repeat (4) @(negedge i_lpc_clk);
            acc(0, 16'h060f, 0, 0, 0);
        end
        sel = 0;
        repeat (4) @(negedge i_lpc_clk);
        acc(0, 16'h060f, 0, 1, {U_RUNTIME, 4'hf});
        $display("test lpc done");
        dchan = $random(seed);
        dact = 1;
        @(negedge i_sys_clk) dreq = 1;
        @(negedge i_sys_clk) dreq = 0;
        for (int i = 0; i < 20 && ldrq_n !== 1'b0; i++) @(negedge i_lpc_clk);
        d = 0;
        repeat (5) begin
            @(negedge i_lpc_clk);
            d = {d[6:0], ldrq_n};
        end
        chk("ldrq", {dchan, dact, 1'b1}, d[4:0]);
        pd_n = 0;
        repeat (6) @(negedge i_lpc_clk);
        chk("ldrq_pd", 0, ldrq_n);
        acc(0, 16'h060f, 0, 0, 0);
        pd_n = 1;
        repeat (6) @(negedge i_lpc_clk);
        chk("ldrq_up", 1, ldrq_n);
        $display("test dma done");
        // Trickle only: pins stay inputs, every source sets its flag and wakes if enabled
        pwr = 0;
        sel = 1;
        drv = '1;
        wl = $random(seed);
        wen = $random(seed);
        men = $random(seed);
        repeat (6) @(negedge i_sys_clk);
        chk("gp_oe_off", 0, gp_oe);
        pulse_clear();
        for (int k = 0; k < EV_N; k++) begin
            src[k] = 1;
            repeat (6) @(negedge i_sys_clk);
            chk("status", 24'h1 << k, stat);
            chk("wake_oe", wen[k], wk_oe);
            chk("mgmt_oe", men[k], mi_oe);
            chk("wake_o", 0, wk_o);
            src[k] = 0;
            repeat (4) @(negedge i_sys_clk);
            pulse_clear();
        end
        chk("od_o", 0, {mi_o, cr_o});
        pwr = 1;
        sel = 0;
        repeat (6) @(negedge i_sys_clk);
        chk("gp_oe_on", drv, gp_oe);
        $display("test wake done");
        need = 1;
        ok = 0;
        repeat (8) begin
            @(negedge i_sys_clk);
            ok |= cr_oe === 1'b1;
        end
        chk("clkrun", 1, ok);
        need = 0;
        $display("test clkrun done");
        report_and_stop();
    end
endmodule : tb_hwk_host_wake
